// ### src/brake_pkg.sv
// shared constants of the brake control and status bit bank
package brake_pkg;
  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_PERIOD_NS = 1000000; // watchdog time base, 1 ms
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ***********************************************************
  // register byte offsets
  // ***********************************************************
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] GUARD_OFF = 8'h04;
  localparam logic [7:0] SENSOR_OFF = 8'h08;
  localparam logic [7:0] KICK_OFF = 8'h0c;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] SPEED_OFF = 8'h14;
  localparam logic [7:0] DUTY_BASE = 8'h20;
  // ***********************************************************
  // field positions and widths
  // ***********************************************************
  localparam int CTRL_SUP_BIT = 0;
  localparam int CTRL_UPPER_LSB = 1;
  localparam int CTRL_LOWER_LSB = 3;
  localparam int CTRL_RATE_LSB = 5;
  localparam int CTRL_SEL_LO_BIT = 7;
  localparam int CTRL_SEL_HI_BIT = 8;
  localparam int CTRL_KIND_BIT = 9;
  localparam int CTRL_W = 10;
  localparam int GUARD_W = 5;
  localparam int SENSOR_W = 10;
  localparam int DUTY_W = 10;
  localparam int DUTY_REG_W = 12; // duty in [9:0], phase in [11:10]
  // ***********************************************************
  // reset values
  // ***********************************************************
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
  localparam logic [GUARD_W-1:0] GUARD_RESET = 5'h00;
  localparam logic [SENSOR_W-1:0] SENSOR_RESET = 10'h000;
  localparam logic [DUTY_REG_W-1:0] DUTY_RESET = 12'h000;
  // ***********************************************************
  // watchdog windows in ms, indexed by select code
  // ***********************************************************
  localparam logic [6:0] UPPER_MS [4] = '{7'h40, 7'h20, 7'h10, 7'h08};
  localparam logic [6:0] LOWER_MS [4] = '{7'h20, 7'h10, 7'h08, 7'h04};
  // pwm: quarter of a 1024-step period, and clocks per step per rate code
  localparam logic [9:0] PHASE_QUARTER = 10'h100;
  localparam logic [15:0] PWM_STEP_DEFAULT [4] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008};
  // watchdog states, gray along off, wait, ok, fail
  typedef enum logic [1:0] {
    WD_OFF = 2'b00,
    WD_WAIT = 2'b01,
    WD_OK = 2'b11,
    WD_FAIL = 2'b10
  } wd_state_t;
endpackage : brake_pkg

// ### src/pwm_if.sv
// shared pwm time base carried to every channel
`timescale 1ns/1ns
interface pwm_if;
  logic [9:0] pos; // position within the 1024-step period
  logic step;      // one-cycle pulse when pos advances
  modport src (output pos, output step);
  modport sink (input pos, input step);
endinterface : pwm_if

// ### src/pwm_channel.sv
// one pwm solenoid channel with phase offset and period-aligned duty
`timescale 1ns/1ns
module pwm_channel (
  input wire logic clk_i,                                  // core clock
  input wire logic rst_n_i,                                // synced reset
  pwm_if.sink tb,                                          // time base
  input wire logic [brake_pkg::DUTY_W-1:0] duty_i,         // written duty
  input wire logic [1:0] phase_i,                          // phase code
  input wire logic permit_i,                               // watchdog permit
  output logic drive_o                                     // driver on
);
  logic [9:0] local_pos;
  logic [brake_pkg::DUTY_W-1:0] duty_reg;
  // shifted position: a quarter period per phase code
  assign local_pos = 10'(tb.pos + 10'(phase_i * brake_pkg::PHASE_QUARTER));
  // new duty only at this channel's period start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_reg <= '0;
      drive_o <= 1'b0;
    end else begin
      if (tb.step && local_pos == 10'h3ff) begin
        duty_reg <= duty_i;
      end
      drive_o <= permit_i && (local_pos < duty_reg);
    end
  end
endmodule : pwm_channel

// ### src/watchdog_timer.sv
// windowed watchdog: service must land between lower and upper limits
`timescale 1ns/1ns
module watchdog_timer #(
  parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES // clocks per ms
) (
  input wire logic clk_i,            // core clock
  input wire logic rst_n_i,          // synced reset
  input wire logic enable_i,         // supervision on
  input wire logic kick_i,           // service pulse
  input wire logic [1:0] upper_i,    // upper window code
  input wire logic [1:0] lower_i,    // lower window code
  output logic ok_o                  // watchdog status
);
  brake_pkg::wd_state_t state_reg, state_next;
  logic [31:0] tick_reg;
  logic [6:0] ms_reg;
  logic ms_tick;
  logic early;
  logic late;
  // millisecond tick and elapsed-ms count since last service
  assign ms_tick = (tick_reg == 32'(TICK_CYCLES - 1));
  assign early = ms_reg < brake_pkg::LOWER_MS[lower_i];
  assign late = ms_reg >= brake_pkg::UPPER_MS[upper_i];
  assign ok_o = (state_reg == brake_pkg::WD_OK);
  // window checks decide the status
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      brake_pkg::WD_OFF: if (enable_i) state_next = brake_pkg::WD_WAIT;
      brake_pkg::WD_WAIT, brake_pkg::WD_FAIL: if (kick_i) state_next = brake_pkg::WD_OK;
      brake_pkg::WD_OK: begin
        if (late || (kick_i && early)) begin
          state_next = brake_pkg::WD_FAIL;
        end
      end
    endcase
    if (!enable_i) begin
      state_next = brake_pkg::WD_OFF;
    end
  end
  // counters restart on every service
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= brake_pkg::WD_OFF;
      tick_reg <= '0;
      ms_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (kick_i || !enable_i) begin
        tick_reg <= '0;
        ms_reg <= '0;
      end else if (ms_tick) begin
        tick_reg <= '0;
        ms_reg <= (ms_reg == 7'h7f) ? ms_reg : 7'(ms_reg + 7'h01);
      end else begin
        tick_reg <= 32'(tick_reg + 32'h1);
      end
    end
  end
endmodule : watchdog_timer

// ### src/brake_ctrl_bits.sv
// brake controller control and status bit bank behind an ahb-lite slave
// ***********************************************************
// ***********************************************************
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
module brake_ctrl_bits #(
  parameter int TICK_CYCLES = brake_pkg::TICK_CYCLES,          // clocks per ms
  parameter int CHANNELS = 4,                                  // pwm channels
  parameter logic [15:0] PWM_STEP_TABLE [4] = brake_pkg::PWM_STEP_DEFAULT // clocks/step
) (
  input wire logic clk_i,                          // core clock, 50 MHz
  input wire logic arst_n_i,                       // async reset, low
  input wire logic hsel_i,                         // ahb select
  input wire logic [31:0] haddr_i,                 // ahb address
  input wire logic [1:0] htrans_i,                 // ahb transfer type
  input wire logic hwrite_i,                       // ahb write
  input wire logic [2:0] hsize_i,                  // ahb size, word only
  input wire logic [31:0] hwdata_i,                // ahb write data
  input wire logic hready_i,                       // ahb ready in
  output logic [31:0] hrdata_o,                    // ahb read data
  output logic hreadyout_o,                        // ahb ready out
  output logic hresp_o,                            // ahb response
  input wire logic battery_overvoltage_i,          // overvoltage fault
  input wire logic [3:0] sensor_supply_current_fault_i, // supply limit faults
  input wire logic reference_level_good_i,         // comparator output
  input wire logic [31:0] speed_counts_i,          // four 8-bit counters
  input wire logic serial_select_n_i,              // serial select, low
  input wire logic main_relay_request_i,           // main relay on request
  input wire logic pump_relay_request_i,           // pump relay on request
  output logic [CHANNELS-1:0] solenoid_drive_o,    // pwm solenoid drivers
  output logic main_relay_gate_o,                  // main relay gate
  output logic pump_relay_gate_o,                  // pump relay gate
  output logic main_relay_ground_short_guard_o,    // guard enable
  output logic main_relay_overcurrent_guard_o,     // guard enable
  output logic pump_relay_ground_short_guard_o,    // guard enable
  output logic pump_relay_overcurrent_guard_o,     // guard enable
  output logic main_relay_leakage_guard_o,         // guard enable
  output logic [3:0] sensor_supply_on_o,           // sensor supplies
  output logic [3:0] sensor_return_on_o,           // sensor returns
  output logic speed_output_enable_a_o,            // speed output a
  output logic speed_output_enable_b_o,            // speed output b
  output logic sensor_kind_o,                      // 1 active sensors
  output logic watchdog_ok_state_o                 // watchdog status
);
  // ***********************************************************
  // reset release
  // ***********************************************************
  logic [1:0] rst_pipe_reg;
  logic rst_n;
  // two flops release the reset synchronously
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_pipe_reg <= 2'b00;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_reg[1];

  // ***********************************************************
  // bus decode
  // ***********************************************************
  logic take;
  logic rd_take;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_ctrl;
  logic wr_guard;
  logic wr_sensor;
  logic wr_kick;
  logic status_rd;
  logic [CHANNELS-1:0] wr_duty;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;
  // address phase taken on select, nonseq/seq and ready
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign rd_take = take && !hwrite_i;
  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == brake_pkg::CTRL_OFF);
  assign wr_guard = wr_pend_reg && (wr_addr_reg == brake_pkg::GUARD_OFF);
  assign wr_sensor = wr_pend_reg && (wr_addr_reg == brake_pkg::SENSOR_OFF);
  assign wr_kick = wr_pend_reg && (wr_addr_reg == brake_pkg::KICK_OFF);
  assign status_rd = rd_take && (haddr_i[7:0] == brake_pkg::STATUS_OFF);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;
  // per-channel duty register write strobes
  for (genvar c = 0; c < CHANNELS; c++) begin : g_duty_dec
    assign wr_duty[c] = wr_pend_reg &&
      (wr_addr_reg == 8'(brake_pkg::DUTY_BASE + 8'(4 * c)));
  end
  // capture the write address phase for the data phase
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= take && hwrite_i;
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  // ***********************************************************
  // control registers
  // ***********************************************************
  logic [brake_pkg::CTRL_W-1:0] ctrl_reg;
  logic [brake_pkg::GUARD_W-1:0] guard_reg;
  logic [brake_pkg::SENSOR_W-1:0] sensor_reg;
  logic [brake_pkg::DUTY_REG_W-1:0] duty_reg [CHANNELS];
  logic watchdog_supervision_on;
  logic [1:0] upper_window_select;
  logic [1:0] lower_window_select;
  logic [1:0] pwm_rate_select;
  logic speed_counter_select_lo;
  logic speed_counter_select_hi;
  logic [1:0] counter_select;
  // software-written fields
  assign watchdog_supervision_on = ctrl_reg[brake_pkg::CTRL_SUP_BIT];
  assign upper_window_select = ctrl_reg[brake_pkg::CTRL_UPPER_LSB +: 2];
  assign lower_window_select = ctrl_reg[brake_pkg::CTRL_LOWER_LSB +: 2];
  assign pwm_rate_select = ctrl_reg[brake_pkg::CTRL_RATE_LSB +: 2];
  assign speed_counter_select_lo = ctrl_reg[brake_pkg::CTRL_SEL_LO_BIT];
  assign speed_counter_select_hi = ctrl_reg[brake_pkg::CTRL_SEL_HI_BIT];
  assign counter_select = {speed_counter_select_hi, speed_counter_select_lo};
  assign sensor_kind_o = ctrl_reg[brake_pkg::CTRL_KIND_BIT];
  // control and guard registers; guards all come up disabled
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= brake_pkg::CTRL_RESET;
      guard_reg <= brake_pkg::GUARD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= hwdata_i[brake_pkg::CTRL_W-1:0];
      end
      if (wr_guard) begin
        guard_reg <= hwdata_i[brake_pkg::GUARD_W-1:0];
      end
    end
  end
  // sensor enables: overvoltage is the only hardware clear and wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sensor_reg <= brake_pkg::SENSOR_RESET;
    end else if (battery_overvoltage_i) begin
      sensor_reg <= brake_pkg::SENSOR_RESET;
    end else if (wr_sensor) begin
      sensor_reg <= hwdata_i[brake_pkg::SENSOR_W-1:0];
    end
  end
  // duty and phase per channel
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < CHANNELS; i++) begin
        duty_reg[i] <= brake_pkg::DUTY_RESET;
      end
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (wr_duty[i]) begin
          duty_reg[i] <= hwdata_i[brake_pkg::DUTY_REG_W-1:0];
        end
      end
    end
  end
  // guard and sensor outputs straight from the registers
  assign main_relay_ground_short_guard_o = guard_reg[0];
  assign main_relay_overcurrent_guard_o = guard_reg[1];
  assign pump_relay_ground_short_guard_o = guard_reg[2];
  assign pump_relay_overcurrent_guard_o = guard_reg[3];
  assign main_relay_leakage_guard_o = guard_reg[4];
  assign sensor_supply_on_o = sensor_reg[3:0];
  assign sensor_return_on_o = sensor_reg[7:4];
  assign speed_output_enable_a_o = sensor_reg[8];
  assign speed_output_enable_b_o = sensor_reg[9];

  // ***********************************************************
  // watchdog and sticky fault
  // ***********************************************************
  logic wd_ok;
  logic wd_ok_prev_reg;
  logic watchdog_fault_sticky;
  logic fault_set;
  logic permit;
  watchdog_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_wd (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .enable_i(watchdog_supervision_on),
    .kick_i(wr_kick),
    .upper_i(upper_window_select),
    .lower_i(lower_window_select),
    .ok_o(wd_ok)
  );
  // a fall of the status under supervision latches the fault
  assign fault_set = watchdog_supervision_on && wd_ok_prev_reg && !wd_ok;
  assign permit = !watchdog_supervision_on || wd_ok;
  assign watchdog_ok_state_o = wd_ok;
  // set beats the clear-on-read in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wd_ok_prev_reg <= 1'b0;
      watchdog_fault_sticky <= 1'b0;
    end else begin
      wd_ok_prev_reg <= wd_ok;
      watchdog_fault_sticky <= fault_set || (watchdog_fault_sticky && !status_rd);
    end
  end

  // ***********************************************************
  // relay gates
  // ***********************************************************
  // relay gates held off while supervision blocks the drivers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      main_relay_gate_o <= 1'b0;
      pump_relay_gate_o <= 1'b0;
    end else begin
      main_relay_gate_o <= main_relay_request_i && permit;
      pump_relay_gate_o <= pump_relay_request_i && permit;
    end
  end

  // ***********************************************************
  // pwm time base and channels
  // ***********************************************************
  pwm_if tb ();
  logic [15:0] presc_reg;
  logic [9:0] pos_reg;
  logic step_now;
  logic [15:0] step_len;
  // rate code picks clocks per step from the table
  assign step_len = PWM_STEP_TABLE[pwm_rate_select];
  assign step_now = (presc_reg >= 16'(step_len - 16'h0001));
  assign tb.pos = pos_reg;
  assign tb.step = step_now;
  // prescaler and 1024-step period position
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= '0;
      pos_reg <= '0;
    end else if (step_now) begin
      presc_reg <= '0;
      pos_reg <= 10'(pos_reg + 10'h001);
    end else begin
      presc_reg <= 16'(presc_reg + 16'h0001);
    end
  end
  // one channel per solenoid driver
  for (genvar c = 0; c < CHANNELS; c++) begin : g_pwm
    pwm_channel u_ch (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .tb(tb.sink),
      .duty_i(duty_reg[c][brake_pkg::DUTY_W-1:0]),
      .phase_i(duty_reg[c][brake_pkg::DUTY_W +: 2]),
      .permit_i(permit),
      .drive_o(solenoid_drive_o[c])
    );
  end

  // ***********************************************************
  // wheel-speed counter capture
  // ***********************************************************
  logic sel_n_prev_reg;
  logic sel_rise;
  logic [7:0] speed_counter_value;
  logic [7:0] speed_pick;
  // selected channel latched when the select line returns high
  assign speed_pick = speed_counts_i[counter_select * 8 +: 8];
  assign sel_rise = serial_select_n_i && !sel_n_prev_reg;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_n_prev_reg <= 1'b1;
      speed_counter_value <= '0;
    end else begin
      sel_n_prev_reg <= serial_select_n_i;
      if (sel_rise) begin
        speed_counter_value <= speed_pick;
      end
    end
  end

  // ***********************************************************
  // read data
  // ***********************************************************
  // read mux on the address phase, unmapped reads give zero
  always_comb begin
    rdata_next = '0;
    unique case (haddr_i[7:0])
      brake_pkg::CTRL_OFF: rdata_next[brake_pkg::CTRL_W-1:0] = ctrl_reg;
      brake_pkg::GUARD_OFF: rdata_next[brake_pkg::GUARD_W-1:0] = guard_reg;
      brake_pkg::SENSOR_OFF: rdata_next[brake_pkg::SENSOR_W-1:0] = sensor_reg;
      brake_pkg::STATUS_OFF: begin
        rdata_next[0] = wd_ok;
        rdata_next[1] = watchdog_fault_sticky;
        rdata_next[5:2] = sensor_supply_current_fault_i;
        rdata_next[6] = reference_level_good_i;
      end
      brake_pkg::SPEED_OFF: rdata_next[7:0] = speed_counter_value;
      default: begin
        for (int i = 0; i < CHANNELS; i++) begin
          if (haddr_i[7:0] == 8'(brake_pkg::DUTY_BASE + 8'(4 * i))) begin
            rdata_next[brake_pkg::DUTY_REG_W-1:0] = duty_reg[i];
          end
        end
      end
    endcase
  end
  // read data held from a register through the data phase
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (rd_take) begin
      rdata_reg <= rdata_next;
    end
  end
endmodule : brake_ctrl_bits

// ### sim/brake_ctrl_bits_chk.sv
// port checker for the brake bit bank
`timescale 1ns/1ns
module brake_ctrl_bits_chk (
  input wire logic clk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic hsel_i, // select
  input wire logic [31:0] haddr_i, // address
  input wire logic [1:0] htrans_i, // transfer
  input wire logic hwrite_i, // write
  input wire logic [31:0] hrdata_o, // read data
  input wire logic battery_overvoltage_i, // overvoltage
  input wire logic [3:0] sensor_supply_current_fault_i, // limit faults
  input wire logic reference_level_good_i, // reference
  input wire logic main_relay_request_i, // request
  input wire logic pump_relay_request_i, // request
  input wire logic main_relay_gate_o, // gate
  input wire logic pump_relay_gate_o, // gate
  input wire logic [3:0] sensor_supply_on_o, // supplies
  input wire logic [3:0] sensor_return_on_o, // returns
  input wire logic speed_output_enable_a_o // speed out
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // address phases taken
  wire logic taken = hsel_i && htrans_i[1];
  wire logic st_rd = taken && !hwrite_i && haddr_i[7:0] == brake_pkg::STATUS_OFF;
  wire logic wr_ph = taken && hwrite_i;
  property p_sup; battery_overvoltage_i |=> sensor_supply_on_o == 4'h0; endproperty
  a_sup: assert property (p_sup) else $error("supply on in overvoltage");
  property p_ret; battery_overvoltage_i |=> sensor_return_on_o == 4'h0; endproperty
  a_ret: assert property (p_ret) else $error("return on in overvoltage");
  property p_spd; battery_overvoltage_i |=> !speed_output_enable_a_o; endproperty
  a_spd: assert property (p_spd) else $error("speed out on in overvoltage");
  property p_keep; |($past(sensor_supply_on_o) & ~sensor_supply_on_o)
    |-> $past(battery_overvoltage_i) || $past(wr_ph, 2); endproperty
  a_keep: assert property (p_keep) else $error("supply cleared without cause");
  property p_lim; st_rd |=> hrdata_o[5:2] == $past(sensor_supply_current_fault_i); endproperty
  a_lim: assert property (p_lim) else $error("limit faults misread");
  property p_ref; st_rd |=> hrdata_o[6] == $past(reference_level_good_i); endproperty
  a_ref: assert property (p_ref) else $error("reference misread");
  property p_mg; main_relay_gate_o |-> $past(main_relay_request_i); endproperty
  a_mg: assert property (p_mg) else $error("main gate without request");
  property p_pg; pump_relay_gate_o |-> $past(pump_relay_request_i); endproperty
  a_pg: assert property (p_pg) else $error("pump gate without request");
  c_ov: cover property (battery_overvoltage_i ##1 !battery_overvoltage_i);
  c_st: cover property (st_rd);
  c_mg: cover property ($rose(main_relay_gate_o));
endmodule : brake_ctrl_bits_chk
bind brake_ctrl_bits brake_ctrl_bits_chk u_chk (.*);

// ### sim/ahb_host.sv
// host model issuing single-word ahb-lite transfers
`timescale 1ns/1ns
module ahb_host (
  input wire logic clk_i, // clock
  input wire logic hready_i, // bus ready
  input wire logic [31:0] hrdata_i, // read data
  output logic hsel_o, // select
  output logic [31:0] haddr_o, // address
  output logic [1:0] htrans_o, // transfer type
  output logic hwrite_o, // write
  output logic [31:0] hwdata_o // write data
);
  int hangs = 0;
  initial {hsel_o, haddr_o, htrans_o, hwrite_o, hwdata_o} = '0;
  // address then data phase, each held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v,
    output logic [31:0] r);
    int n;
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= {24'h0, a};
    hwrite_o <= w;
    htrans_o <= 2'h2;
    for (n = 0; n == 0 || (hready_i !== 1'b1 && n < 64); n++) @(posedge clk_i);
    hangs += int'(n >= 64);
    htrans_o <= 2'h0;
    hwdata_o <= v;
    for (n = 0; n == 0 || (hready_i !== 1'b1 && n < 64); n++) @(posedge clk_i);
    hangs += int'(n >= 64);
    r = hrdata_i;
  endtask : xfer
endmodule : ahb_host

// ### sim/test_brake_ctrl_bits.sv
// self-checking bench for the brake bit bank
`timescale 1ns/1ns
module test_brake_ctrl_bits;
  localparam int T = 10; // clocks per ms, shortened
  logic clk_i = 1'b0;
  logic arst_n_i, ov, refg, ssn, mreq, preq, keep;
  logic [3:0] cf;
  logic [31:0] cnt, q, d, x = 32'd90;
  wire hsel, hwrite, rdy, mg, pg, kind, wdok, spa, spb;
  wire [1:0] htrans;
  wire [31:0] haddr, hwdata, hrdata;
  wire [3:0] sol, sup, ret;
  wire [4:0] g;
  int fails = 0, comparisons = 0, n;
  brake_ctrl_bits #(.TICK_CYCLES(T)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(),
    .battery_overvoltage_i(ov), .sensor_supply_current_fault_i(cf),
    .reference_level_good_i(refg), .speed_counts_i(cnt), .serial_select_n_i(ssn),
    .main_relay_request_i(mreq), .pump_relay_request_i(preq), .solenoid_drive_o(sol),
    .main_relay_gate_o(mg), .pump_relay_gate_o(pg), .main_relay_ground_short_guard_o(g[0]),
    .main_relay_overcurrent_guard_o(g[1]), .pump_relay_ground_short_guard_o(g[2]),
    .pump_relay_overcurrent_guard_o(g[3]), .main_relay_leakage_guard_o(g[4]),
    .sensor_supply_on_o(sup), .sensor_return_on_o(ret), .speed_output_enable_a_o(spa),
    .speed_output_enable_b_o(spb), .sensor_kind_o(kind), .watchdog_ok_state_o(wdok));
  ahb_host host (.clk_i(clk_i), .hready_i(rdy), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  // stimulus and expectations
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  function automatic int win_hi(input int c); return 64 >> c; endfunction : win_hi
  function automatic int win_lo(input int c); return 32 >> c; endfunction : win_lo
  function automatic logic lead(input int p, input logic [31:0] dv);
    return 256 * p < dv;
  endfunction : lead
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] v); host.xfer(1'b1, a, v, q); endtask : wr
  task automatic rd(input logic [7:0] a); host.xfer(1'b0, a, 32'h0, q); endtask : rd
  task automatic complete_run();
    fails += host.hangs;
    $display("counts: %0d mismatches, %0d comparisons", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial forever #10 clk_i = ~clk_i;
  // hang limit
  initial begin
    repeat (90000) @(posedge clk_i);
    fails++;
    complete_run();
  end
  // main sequence
  initial begin
    {arst_n_i, ov, refg, mreq, preq, cf, cnt} = '0;
    ssn = 1'b1;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(brake_pkg::GUARD_OFF);
    check(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      d = rnd() & 32'h1f;
      {preq, mreq} <= d[1:0];
      wr(brake_pkg::GUARD_OFF, d);
      rd(brake_pkg::GUARD_OFF);
      check(q, d);
      @(negedge clk_i);
      check(g, d);
    end
    $display("guard test done");
    for (int i = 0; i < 4; i++) begin
      d = rnd() & 32'h3ff;
      wr(brake_pkg::SENSOR_OFF, d);
      {refg, cf} <= d[4:0];
      repeat (2) @(negedge clk_i);
      check({spb, spa, ret, sup}, d);
      rd(brake_pkg::STATUS_OFF);
      check(q[6:2], {refg, cf});
      ov <= 1'b1;
      repeat (2) @(negedge clk_i);
      check({spb, spa, ret, sup}, 32'h0);
      @(posedge clk_i);
      ov <= 1'b0;
    end
    $display("sensor test done");
    for (int ch = 0; ch < 4; ch++) begin
      cnt <= rnd();
      wr(brake_pkg::CTRL_OFF, (ch << 7) | ((ch & 1) << 9));
      ssn <= 1'b0;
      @(posedge clk_i);
      ssn <= 1'b1;
      d = cnt;
      repeat (3) @(posedge clk_i);
      cnt <= ~d;
      rd(brake_pkg::SPEED_OFF);
      check(q, (d >> (8 * ch)) & 32'hff);
      check(kind, ch[0]);
    end
    $display("speed test done");
    {preq, mreq} <= 2'b11;
    for (int i = 0; i < 4; i++) begin
      wr(brake_pkg::CTRL_OFF, 32'h0);
      wr(brake_pkg::CTRL_OFF, (i << 3) | (i << 1) | 1);
      rd(brake_pkg::STATUS_OFF);
      @(negedge clk_i);
      check({pg, mg, wdok}, 3'h0);
      wr(brake_pkg::KICK_OFF, 32'h0);
      repeat (win_lo(i) * T + 5) @(negedge clk_i);
      check({pg, mg, wdok}, 3'h7);
      wr(brake_pkg::KICK_OFF, 32'h0);
      @(negedge clk_i);
      check(wdok, 1'b1);
      repeat (win_hi(i) * T + 5) @(negedge clk_i);
      check({pg, mg, wdok}, 3'h0);
      rd(brake_pkg::STATUS_OFF);
      check(q[1], 1'b1);
      rd(brake_pkg::STATUS_OFF);
      check(q[1], 1'b0);
      wr(brake_pkg::KICK_OFF, 32'h0);
      wr(brake_pkg::KICK_OFF, 32'h0);
      @(negedge clk_i);
      check(wdok, 1'b0);
    end
    $display("watchdog test done");
    for (int r = 0; r < 4; r++) begin
      d = (rnd() & 32'h3ff) | 32'h1;
      wr(brake_pkg::DUTY_BASE, d);
      wr(brake_pkg::DUTY_BASE + 8'h04, d | (r << 10));
      wr(brake_pkg::CTRL_OFF, r << 5);
      repeat (2048 << r) @(posedge clk_i);
      n = 0;
      repeat (1024 << r) begin
        @(negedge clk_i);
        n += int'(sol[0] === 1'b1);
      end
      check(n, d << r);
      keep = 1'b1;
      for (n = 0; n < (2048 << r) && !(sol[0] === 1'b1 && keep === 1'b0); n++) begin
        keep = sol[0];
        @(negedge clk_i);
      end
      check(sol[1], lead(r, d));
    end
    $display("pwm test done");
    complete_run();
  end
endmodule : test_brake_ctrl_bits
